// ---- verification/clg_host_model.sv ----
`timescale 1ns/10ps
// ----
// host I/O cycles
// ----
module clg_host_model
  import clg_pkg::*;
(
  input  wire logic   clock_i,
  output clg_io_req_t io_req_o,
  output logic        io_done_o
);
  initial begin
    io_req_o = '0;
    io_done_o = 1'b0;
  end
  task automatic cyc(input logic rd, input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i);
    io_req_o  <= '{rd: rd, wr: wr, addr: a, wdata: d};
    io_done_o <= 1'b1;
    #1;
  endtask : cyc
  // released bus shows the inverse, so a stale value cannot pass
  task automatic idle();
    @(posedge clock_i);
    io_req_o  <= '{rd: 1'b0, wr: 1'b0, addr: ~io_req_o.addr, wdata: ~io_req_o.wdata};
    io_done_o <= 1'b0;
    #1;
  endtask : idle
endmodule : clg_host_model

// ---- verification/test_config_register_lock_gate.sv ----
`timescale 1ns/10ps
`include "clg_cfg.svh"
module test_config_register_lock_gate
  import clg_pkg::*;
;
  logic clock_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, par_dir_i = 1'b0;
  logic [3:0] dma1_mask_i = 4'hF, dma2_mask_i = 4'hF;
  logic [15:0] rdata_o, ems [3] = '{`CLG_EMS_PTR_PORT, `CLG_EMS_PAGE_PORT, `CLG_P70_SHD_PORT};
  logic rdata_vld_o, locked_o, to_at_bus_o, reg_sel_o, legacy_sel_o, io_done, tog = 1'b0;
  clg_io_req_t io_req;
  logic [31:0] seed = 32'd96719, r;
  int err_count = 0, compares = 0, cycles = 0;
  always #2 clock_i = ~clock_i;
  clg_host_model HOST (.clock_i(clock_i), .io_req_o(io_req), .io_done_o(io_done));
  clg_lock_gate DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .io_req_i(io_req), .io_done_i(io_done), .dma1_mask_i(dma1_mask_i),
    .dma2_mask_i(dma2_mask_i), .par_dir_i(par_dir_i), .rdata_o(rdata_o),
    .rdata_vld_o(rdata_vld_o), .locked_o(locked_o), .to_at_bus_o(to_at_bus_o),
    .reg_sel_o(reg_sel_o), .legacy_sel_o(legacy_sel_o));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [15:0] exp_st(input logic t, input logic [3:0] d1, d2, input logic p);
    return {t, 3'h0, d2, d1, p, 3'h0};
  endfunction : exp_st
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1 chk(locked_o, 16'h0001);
    HOST.cyc(1'b1, 1'b0, `CLG_STATUS_PORT, 16'h0000);
    chk(to_at_bus_o, 16'h0001);
    chk(reg_sel_o, 16'h0000);
    HOST.idle();
    chk(rdata_vld_o, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      HOST.cyc(1'b1, 1'b0, ems[i], 16'h0000);
      chk(to_at_bus_o, 16'h0000);
    end
    HOST.cyc(1'b0, 1'b1, 16'hF373, 16'h00DA);
    HOST.idle();
    chk(locked_o, 16'h0001);
    r = xs();
    HOST.cyc(1'b0, 1'b1, `CLG_KEY_PORT, {r[7:0], 8'hDA});
    chk(reg_sel_o, 16'h0001);
    HOST.idle();
    chk(locked_o, 16'h0000);
    HOST.cyc(1'b1, 1'b0, `CLG_KEY_PORT, 16'h0000);
    HOST.idle();
    chk(locked_o, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      r = xs();
      @(posedge clock_i);
      {dma1_mask_i, dma2_mask_i, par_dir_i} <= r[8:0];
      if (k[0]) HOST.cyc(1'b0, 1'b1, `CLG_STATUS_PORT, r[31:16]);
      repeat (3) HOST.idle();
      HOST.cyc(1'b1, 1'b0, `CLG_STATUS_PORT, 16'h0000);
      HOST.idle();
      chk(rdata_vld_o, 16'h0001);
      chk(rdata_o, exp_st(tog, r[8:5], r[4:1], r[0]));
      tog = ~tog;
      HOST.cyc(1'b1, 1'b0, {r[15:10], 2'b00, 2'b00, r[21:16]}, 16'h0000);
      chk(legacy_sel_o, 16'h0001);
      chk(to_at_bus_o, 16'h0000);
    end
    HOST.cyc(1'b1, 1'b0, 16'h1872, 16'h0000);
    chk(to_at_bus_o, 16'h0000);
    r = xs();
    HOST.cyc(1'b0, 1'b1, `CLG_KEY_PORT, {8'hDA, (r[7:0] == 8'hDA) ? 8'h25 : r[7:0]});
    HOST.idle();
    chk(locked_o, 16'h0001);
    HOST.cyc(1'b1, 1'b0, 16'h1872, 16'h0000);
    chk(to_at_bus_o, 16'h0001);
    // a frozen clock enable must hold the lock
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    HOST.cyc(1'b0, 1'b1, `CLG_KEY_PORT, 16'h00DA);
    HOST.idle();
    chk(locked_o, 16'h0001);
    print_verdict();
  end
endmodule : test_config_register_lock_gate

// ---- verilog/clg_cfg.svh ----
`ifndef CLG_CFG_SVH
`define CLG_CFG_SVH
// port addresses, all sixteen bits decoded
`define CLG_KEY_PORT      16'hF073
`define CLG_STATUS_PORT   16'hFC72
`define CLG_EMS_PTR_PORT  16'hE072
`define CLG_EMS_PAGE_PORT 16'hE872
`define CLG_P70_SHD_PORT  16'hE472
// gated window: xx72 with the high byte from 10 to FC
`define CLG_GATE_LO_BYTE  8'h72
`define CLG_GATE_HI_MIN   8'h10
`define CLG_GATE_HI_MAX   8'hFC
// the top of the map also uses the x472 and xC72 slots
`define CLG_GATE_HI_D4    8'hD4
`define CLG_GATE_HI_DC    8'hDC
`define CLG_GATE_HI_F4    8'hF4
`define CLG_GATE_HI_FC    8'hFC
// low ten bits of the key port, shared by its legacy aliases
`define CLG_KEY_LOW10     10'h073
// legacy range compare uses address bits 9..0; the fully decoded gated and key ports are excluded
`define CLG_LEGACY_MAX    10'h0FF
`define CLG_UNLOCK_KEY    8'hDA
// status field positions
`define CLG_ST_TOGGLE     15
`define CLG_ST_DMA2_HI    11
`define CLG_ST_DMA2_LO    8
`define CLG_ST_DMA1_HI    7
`define CLG_ST_DMA1_LO    4
`define CLG_ST_PDIR       3
// reset values
`define CLG_RST_LOCKED    1'b1
`define CLG_RST_TOGGLE    1'b0
`endif

// ---- verilog/clg_lock_gate.sv ----
`timescale 1ns/10ps
`include "clg_cfg.svh"

module clg_lock_gate
  import clg_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire clg_io_req_t io_req_i,
  input  wire logic        io_done_i,
  input  wire logic [3:0]  dma1_mask_i,
  input  wire logic [3:0]  dma2_mask_i,
  input  wire logic        par_dir_i,
  output logic [15:0]      rdata_o,
  output logic             rdata_vld_o,
  output logic             locked_o,
  output logic             to_at_bus_o,
  output logic             reg_sel_o,
  output logic             legacy_sel_o
);

  //--------------------------------------------------------------
  // address classification
  //--------------------------------------------------------------
  // gated window match
  function automatic logic is_gated(input logic [15:0] a);
    if (a == `CLG_EMS_PTR_PORT || a == `CLG_EMS_PAGE_PORT || a == `CLG_P70_SHD_PORT) begin
      is_gated = 1'b0;
    end else if (a[7:0] == `CLG_GATE_LO_BYTE && a[15:8] >= `CLG_GATE_HI_MIN &&
                 a[15:8] <= `CLG_GATE_HI_MAX) begin
      // x072 and x872 slots, plus the four odd slots at the top of the map
      is_gated = (a[10:8] == 3'h0) || (a[15:8] == `CLG_GATE_HI_D4) ||
                 (a[15:8] == `CLG_GATE_HI_DC) || (a[15:8] == `CLG_GATE_HI_F4) ||
                 (a[15:8] == `CLG_GATE_HI_FC);
    end else begin
      is_gated = 1'b0;
    end
  endfunction : is_gated

  logic        cyc;
  logic        gated_hit;
  logic        key_hit;
  logic        stat_hit;
  logic        legacy_hit;
  logic        locked_r;
  logic        toggle_r;
  logic [3:0]  dma1_s1_r, dma1_s2_r, dma2_s1_r, dma2_s2_r;
  logic        pdir_s1_r, pdir_s2_r;
  clg_route_t  route;

  assign cyc        = io_req_i.rd | io_req_i.wr;
  assign key_hit    = (io_req_i.addr == `CLG_KEY_PORT);
  assign stat_hit   = (io_req_i.addr == `CLG_STATUS_PORT);
  assign gated_hit  = is_gated(io_req_i.addr) | stat_hit;
  // legacy ports look at bits 9..0, less the fully decoded gated and key ports
  assign legacy_hit = (io_req_i.addr[9:0] <= `CLG_LEGACY_MAX) & ~gated_hit & ~key_hit;

  //--------------------------------------------------------------
  // routing
  //--------------------------------------------------------------
  always_comb begin
    route = CLG_RT_NONE;
    if (cyc) begin
      if (gated_hit && locked_r) begin
        route = CLG_RT_AT_BUS;
      end else if (gated_hit || key_hit) begin
        route = CLG_RT_INTERNAL;
      end
    end
  end

  assign to_at_bus_o  = (route == CLG_RT_AT_BUS);
  assign reg_sel_o    = (route == CLG_RT_INTERNAL);
  assign legacy_sel_o = cyc & legacy_hit;
  assign locked_o     = locked_r;

  //--------------------------------------------------------------
  // input synchronisers
  //--------------------------------------------------------------
  // masks reset to disabled so a read right after reset shows idle channels
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dma1_s1_r <= 4'hF;
      dma1_s2_r <= 4'hF;
      dma2_s1_r <= 4'hF;
      dma2_s2_r <= 4'hF;
      pdir_s1_r <= 1'b0;
      pdir_s2_r <= 1'b0;
    end else if (clk_en_i) begin
      dma1_s1_r <= dma1_mask_i;
      dma1_s2_r <= dma1_s1_r;
      dma2_s1_r <= dma2_mask_i;
      dma2_s2_r <= dma2_s1_r;
      pdir_s1_r <= par_dir_i;
      pdir_s2_r <= pdir_s1_r;
    end
  end

  //--------------------------------------------------------------
  // lock state
  //--------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      locked_r <= `CLG_RST_LOCKED;
    end else if (clk_en_i && io_req_i.wr && key_hit && io_done_i) begin
      // upper byte ignored; key compare
      // taken only on the completing edge, so a stretched cycle counts once
      locked_r <= (io_req_i.wdata[7:0] != `CLG_UNLOCK_KEY);
    end
  end

  //--------------------------------------------------------------
  // status port
  //--------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      toggle_r <= `CLG_RST_TOGGLE;
    end else if (clk_en_i && reg_sel_o && io_req_i.rd && stat_hit && io_done_i) begin
      toggle_r <= ~toggle_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_o     <= 16'h0000;
      rdata_vld_o <= 1'b0;
    end else if (clk_en_i) begin
      rdata_vld_o <= reg_sel_o & io_req_i.rd & stat_hit;
      if (reg_sel_o && io_req_i.rd && stat_hit) begin
        rdata_o <= 16'h0000;
        rdata_o[`CLG_ST_TOGGLE] <= toggle_r;
        rdata_o[`CLG_ST_DMA2_HI:`CLG_ST_DMA2_LO] <= dma2_s2_r;
        rdata_o[`CLG_ST_DMA1_HI:`CLG_ST_DMA1_LO] <= dma1_s2_r;
        rdata_o[`CLG_ST_PDIR] <= pdir_s2_r;
      end
    end
  end

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  sequence key_write_s(logic [7:0] k);
    clk_en_i && io_req_i.wr && key_hit && io_done_i && io_req_i.wdata[7:0] == k;
  endsequence

  sequence stat_read_s;
    clk_en_i && reg_sel_o && io_req_i.rd && stat_hit;
  endsequence

  property unlock_p;
    @(posedge clock_i) disable iff (!rst_n_i)
      key_write_s(`CLG_UNLOCK_KEY) |=> !locked_r;
  endproperty

  chk_unlock_key: assert property (unlock_p)
    else $error("key DA did not unlock");

  chk_lock_other: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && io_req_i.wr && key_hit && io_done_i &&
     io_req_i.wdata[7:0] != `CLG_UNLOCK_KEY) |=> locked_r)
    else $error("non-key write did not lock");

  chk_toggle_flip: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && reg_sel_o && io_req_i.rd && stat_hit && io_done_i) |=>
      toggle_r != $past(toggle_r))
    else $error("toggle bit did not flip");

  chk_locked_forward: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cyc && gated_hit && locked_r) |-> (to_at_bus_o && !reg_sel_o))
    else $error("locked access not forwarded");

  chk_key_open: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cyc && key_hit) |-> (reg_sel_o && !to_at_bus_o))
    else $error("key port was gated");

  chk_dma_mirror: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && reg_sel_o && io_req_i.rd && stat_hit) |=>
      rdata_vld_o && rdata_o[11:8] == $past(dma2_s2_r))
    else $error("dma mask mirror wrong");

  chk_dma1_mirror: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    stat_read_s |=> (rdata_vld_o && rdata_o[7:4] == $past(dma1_s2_r)))
    else $error("first dma mask mirror wrong");

  chk_unused_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rdata_vld_o |-> (rdata_o[14:12] == 3'h0 && rdata_o[2:0] == 3'h0))
    else $error("unused status bits not zero");

  chk_pdir_mirror: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && reg_sel_o && io_req_i.rd && stat_hit) |=> rdata_o[3] == $past(pdir_s2_r))
    else $error("direction mirror wrong");

  chk_reset_locked: assert property (@(posedge clock_i)
    !rst_n_i |=> locked_r)
    else $error("not locked after reset");

  //--------------------------------------------------------------
  // routing and status extras
  //--------------------------------------------------------------
  // legacy stays open
  chk_legacy_open: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    legacy_sel_o |-> (!to_at_bus_o && !reg_sel_o))
    else $error("legacy port was gated");

  chk_ems_open: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cyc && (io_req_i.addr == `CLG_EMS_PTR_PORT || io_req_i.addr == `CLG_EMS_PAGE_PORT ||
             io_req_i.addr == `CLG_P70_SHD_PORT)) |-> !to_at_bus_o)
    else $error("ems or shadow port was gated");

  chk_unlocked_internal: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cyc && gated_hit && !locked_r) |-> (reg_sel_o && !to_at_bus_o))
    else $error("unlocked access not internal");

  chk_status_ro: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && io_req_i.wr && !io_req_i.rd && stat_hit) |=> $stable(toggle_r))
    else $error("status write moved toggle");

  chk_toggle_data: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    stat_read_s |=> rdata_o[15] == $past(toggle_r))
    else $error("toggle bit not in status data");

  chk_locked_noflip: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && io_req_i.rd && stat_hit && locked_r) |=> ($stable(toggle_r) && !rdata_vld_o))
    else $error("locked read reached status port");

  chk_route_excl: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !(to_at_bus_o && reg_sel_o))
    else $error("cycle routed twice");

  chk_key_full: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cyc && io_req_i.addr[9:0] == `CLG_KEY_LOW10 && !key_hit) |-> !reg_sel_o)
    else $error("key alias was decoded");

  chk_key_read_noop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && io_req_i.rd && !io_req_i.wr && key_hit) |=> $stable(locked_r))
    else $error("key read changed lock");

  chk_lock_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && !(io_req_i.wr && key_hit && io_done_i)) |=> $stable(locked_r))
    else $error("lock changed without key write");

  chk_reset_toggle: assert property (@(posedge clock_i)
    !rst_n_i |=> (toggle_r == `CLG_RST_TOGGLE && !rdata_vld_o))
    else $error("toggle not at reset value");

  // status data stands between reads
  chk_rdata_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clk_en_i && !(reg_sel_o && io_req_i.rd && stat_hit)) |=> ($stable(rdata_o) && !rdata_vld_o))
    else $error("status data moved without read");

  // low clock enable freezes the lock, the toggle bit and the status data
  chk_freeze_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !clk_en_i |=> ($stable(locked_r) && $stable(toggle_r) && $stable(rdata_o)))
    else $error("state moved while frozen");

  // idle bus selects nothing
  chk_idle_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !cyc |-> (!to_at_bus_o && !reg_sel_o && !legacy_sel_o))
    else $error("idle bus selected a port");

endmodule : clg_lock_gate

// ---- verilog/clg_pkg.sv ----
package clg_pkg;
  // one host I/O cycle as presented to the gate
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } clg_io_req_t;

  // routing decision for the current cycle
  typedef enum logic [1:0] {
    CLG_RT_NONE,
    CLG_RT_INTERNAL,
    CLG_RT_AT_BUS
  } clg_route_t;
endpackage : clg_pkg
